// ### design/tpau_pkg.sv
// Purpose: Constants for the table pointer access unit.
// Assumes: AXI4-Lite register access, 32-bit data, one register per aligned word.
// Notes:   All offsets are byte addresses.
//
// Contract
// - Pointer is low byte, high byte and six low bits of upper byte.
// - Lower 21 pointer bits address the 2 Mbyte program space.
// - Top pointer bit set selects the configuration space.
// - Automatic pointer updates change only the lower 21 bits.
// - Every access uses the complete 22-bit pointer as its address.
// - Plain form leaves the pointer unchanged.
// - Post-increment form accesses, then adds one to the pointer.
// - Post-decrement form accesses, then subtracts one from the pointer.
// - Pre-increment form adds one first, then accesses the new address.
// - A table read moves exactly one byte per operation.
// - A table read loads the latch with the addressed byte.
// - Pointer bit zero picks the high or low byte of a word.
// - A table write drives pointer and latch onto external buses.
// - In programming mode, writes program 64-byte blocks at once.
// - Write blocks align to the code protection block boundaries.
// - Upper byte: select bit at 5, pointer 20..16 below, top two zero.
// - The latch is an 8-bit software-visible transfer register.
// - Without external memory, a normal table write takes two cycles as no-op.
package tpau_pkg;
   localparam int          PTR_W          = 22;
   localparam int          LOW_W          = 21;
   localparam int          CFG_BIT        = 21;
   localparam int          UPPER_SEL_BIT  = 5;
   localparam int          BLOCK_BYTES    = 64;
   localparam int          BLOCK_AW       = 6;
   localparam logic [5:0]  BLOCK_LAST     = 6'h3f;
   localparam logic [7:0]  ADDR_PTR_LOW   = 8'h00;
   localparam logic [7:0]  ADDR_PTR_HIGH  = 8'h04;
   localparam logic [7:0]  ADDR_PTR_UPPER = 8'h08;
   localparam logic [7:0]  ADDR_LATCH     = 8'h0c;
   localparam logic [7:0]  ADDR_CONTROL   = 8'h10;
   localparam logic [7:0]  ADDR_STATUS    = 8'h14;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;
   localparam logic [1:0]  MODE_PLAIN     = 2'h0;
   localparam logic [1:0]  MODE_POST_INC  = 2'h1;
   localparam logic [1:0]  MODE_POST_DEC  = 2'h2;
   localparam logic [1:0]  MODE_PRE_INC   = 2'h3;
   localparam logic [21:0] PTR_RESET      = 22'h000000;
   localparam logic [7:0]  LATCH_RESET    = 8'h00;
   localparam logic [20:0] LOW_ONE        = 21'h000001;
   typedef enum logic [1:0] {ST_IDLE, ST_RD_WAIT, ST_WR_2, ST_FIN} tpau_state_type;
endpackage

// ### design/tpau_table_access.sv
// Purpose: Table pointer, transfer latch and table read/write sequencing.
// Assumes: Core and memory ports are on aclk; AXI4-Lite reaches the registers.
// Notes:   A core operation finishing in the same cycle as a bus pointer write wins.
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
module tpau_table_access #(
   parameter bit EXT_MEM_PRESENT = 1'b1
) (
   input  wire logic                     aclk,
   input  wire logic                     aresetn,
   input  wire logic [7:0]               s_axi_awaddr,
   input  wire logic                     s_axi_awvalid,
   output logic                          s_axi_awready,
   input  wire logic [31:0]              s_axi_wdata,
   input  wire logic [3:0]               s_axi_wstrb,
   input  wire logic                     s_axi_wvalid,
   output logic                          s_axi_wready,
   output logic [1:0]                    s_axi_bresp,
   output logic                          s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   input  wire logic [7:0]               s_axi_araddr,
   input  wire logic                     s_axi_arvalid,
   output logic                          s_axi_arready,
   output logic [31:0]                   s_axi_rdata,
   output logic [1:0]                    s_axi_rresp,
   output logic                          s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   input  wire logic                     op_valid,
   input  wire logic                     op_write,
   input  wire logic [1:0]               op_mode,
   output logic                          op_ready,
   output logic                          op_done,
   output logic [tpau_pkg::PTR_W-2:0]    mem_word_addr,
   output logic                          mem_rd_req,
   input  wire logic                     mem_rd_ack,
   input  wire logic [15:0]              mem_rd_word,
   output logic [tpau_pkg::PTR_W-1:0]    ext_addr,
   output logic [7:0]                    ext_data,
   output logic                          ext_wr,
   output logic                          prog_commit,
   output logic [tpau_pkg::PTR_W-1:0]    prog_base,
   input  wire logic [tpau_pkg::BLOCK_AW-1:0] prog_rd_idx,
   output logic [7:0]                    prog_rd_byte
);
   import tpau_pkg::*;

   tpau_state_type     st_q;
   logic [PTR_W-1:0]   ptr_q;
   logic [PTR_W-1:0]   acc_q;
   logic [PTR_W-1:0]   fin_ptr_q;
   logic [7:0]         latch_q;
   logic               prog_mode_q;
   logic               is_write_q;
   logic [7:0]         blk_buf [BLOCK_BYTES];
   logic               aw_full_q;
   logic               w_full_q;
   logic [7:0]         awaddr_q;
   logic [7:0]         wdata_q;
   logic               wstrb0_q;
   logic               awready_q;
   logic               wready_q;
   logic               bvalid_q;
   logic [1:0]         bresp_q;
   logic               arready_q;
   logic               rvalid_q;
   logic [31:0]        rdata_q;
   logic [1:0]         rresp_q;
   logic               op_ready_q;
   logic               op_done_q;
   logic [PTR_W-2:0]   mem_addr_q;
   logic               mem_rd_req_q;
   logic [PTR_W-1:0]   ext_addr_q;
   logic [7:0]         ext_data_q;
   logic               ext_wr_q;
   logic               prog_commit_q;
   logic [PTR_W-1:0]   prog_base_q;
   logic [7:0]         prog_rd_byte_q;

   // Bus handshake decode.
   wire aw_take    = s_axi_awvalid & awready_q;
   wire w_take     = s_axi_wvalid & wready_q;
   wire wr_fire    = aw_full_q & w_full_q & ~bvalid_q;
   wire aw_full_d  = (aw_full_q | aw_take) & ~wr_fire;
   wire w_full_d   = (w_full_q | w_take) & ~wr_fire;
   wire bvalid_d   = (bvalid_q & ~s_axi_bready) | wr_fire;
   wire ar_take    = s_axi_arvalid & arready_q;
   wire rvalid_d   = (rvalid_q & ~s_axi_rready) | ar_take;
   wire wr_en      = wr_fire & wstrb0_q;
   wire hit_low    = (awaddr_q == ADDR_PTR_LOW);
   wire hit_high   = (awaddr_q == ADDR_PTR_HIGH);
   wire hit_upper  = (awaddr_q == ADDR_PTR_UPPER);
   wire hit_latch  = (awaddr_q == ADDR_LATCH);
   wire hit_ctrl   = (awaddr_q == ADDR_CONTROL);
   wire wr_mapped  = hit_low | hit_high | hit_upper | hit_latch | hit_ctrl | 
                     (awaddr_q == ADDR_STATUS);

   // The upper byte shows the select bit and pointer bits 20..16; its top two read zero.
   wire [7:0] upper_rd = {2'h0, ptr_q[PTR_W-1:16]};
   wire       busy     = (st_q != ST_IDLE);
   wire [31:0] status_rd = {30'h0, prog_mode_q, busy};
   wire [7:0] rd_addr = s_axi_araddr;
   wire rd_mapped = (rd_addr == ADDR_PTR_LOW) | (rd_addr == ADDR_PTR_HIGH) |
                    (rd_addr == ADDR_PTR_UPPER) | (rd_addr == ADDR_LATCH) |
                    (rd_addr == ADDR_CONTROL) | (rd_addr == ADDR_STATUS);
   wire [31:0] rd_val =
      (rd_addr == ADDR_PTR_LOW)   ? {24'h0, ptr_q[7:0]} :
      (rd_addr == ADDR_PTR_HIGH)  ? {24'h0, ptr_q[15:8]} :
      (rd_addr == ADDR_PTR_UPPER) ? {24'h0, upper_rd} :
      (rd_addr == ADDR_LATCH)     ? {24'h0, latch_q} :
      (rd_addr == ADDR_CONTROL)   ? {31'h0, prog_mode_q} :
      (rd_addr == ADDR_STATUS)    ? status_rd : 32'h0;

   // Core operation decode; adjustments touch only the lower 21 bits.
   wire        issue    = (st_q == ST_IDLE) & op_valid;
   wire [20:0] ptr_inc  = ptr_q[LOW_W-1:0] + LOW_ONE;
   wire [PTR_W-1:0] acc_d = (op_mode == MODE_PRE_INC) ?
                            {ptr_q[CFG_BIT], ptr_inc} : ptr_q;
   wire [20:0] acc_inc  = acc_d[LOW_W-1:0] + LOW_ONE;
   wire [20:0] acc_dec  = acc_d[LOW_W-1:0] - LOW_ONE;
   wire [PTR_W-1:0] fin_d =
      (op_mode == MODE_POST_INC) ? {acc_d[CFG_BIT], acc_inc} :
      (op_mode == MODE_POST_DEC) ? {acc_d[CFG_BIT], acc_dec} :
      acc_d;
   wire        do_prog  = issue & op_write & prog_mode_q;
   wire        do_ext   = issue & op_write & ~prog_mode_q & EXT_MEM_PRESENT;
   wire        blk_end  = (acc_d[BLOCK_AW-1:0] == BLOCK_LAST);
   // Bit zero of the pointer picks the byte of the returned word.
   wire        ptr_sel_hi = acc_q[0];
   wire [7:0]  rd_byte  = ptr_sel_hi ? mem_rd_word[15:8] : mem_rd_word[7:0];

   // Pointer is the three byte registers joined; the select bit is part of it.
   wire [PTR_W-1:0] ptr_bus =
      {hit_upper ? wdata_q[UPPER_SEL_BIT:0] : ptr_q[PTR_W-1:16],
       hit_high  ? wdata_q : ptr_q[15:8],
       hit_low   ? wdata_q : ptr_q[7:0]};
   wire [PTR_W-1:0] ptr_d = (st_q == ST_FIN) ? fin_ptr_q :
                            wr_en ? ptr_bus : ptr_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
      end else begin
         aw_full_q <= aw_full_d;
         w_full_q  <= w_full_d;
         awready_q <= ~aw_full_d;
         wready_q  <= ~w_full_d;
         bvalid_q  <= bvalid_d;
         arready_q <= ~rvalid_d;
         rvalid_q  <= rvalid_d;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awaddr_q <= 8'h00;
         wdata_q  <= 8'h00;
         wstrb0_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
         rdata_q  <= 32'h0;
         rresp_q  <= RESP_OKAY;
      end else begin
         if (aw_take) begin
            awaddr_q <= s_axi_awaddr;
         end
         if (w_take) begin
            wdata_q  <= s_axi_wdata[7:0];
            wstrb0_q <= s_axi_wstrb[0];
         end
         if (wr_fire) begin
            bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
         end
         if (ar_take) begin
            rdata_q <= rd_val;
            rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // Pointer, latch and programming mode; all clear on reset.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ptr_q       <= PTR_RESET;
         latch_q     <= LATCH_RESET;
         prog_mode_q <= 1'b0;
      end else begin
         ptr_q <= ptr_d;
         if (st_q == ST_RD_WAIT && mem_rd_ack) begin
            latch_q <= rd_byte;
         end else if (wr_en && hit_latch) begin
            latch_q <= wdata_q;
         end
         if (wr_en && hit_ctrl) begin
            prog_mode_q <= wdata_q[0];
         end
      end
   end

   // Operation sequencer.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q          <= ST_IDLE;
         acc_q         <= PTR_RESET;
         fin_ptr_q     <= PTR_RESET;
         is_write_q    <= 1'b0;
         op_ready_q    <= 1'b0;
         op_done_q     <= 1'b0;
         mem_addr_q    <= '0;
         mem_rd_req_q  <= 1'b0;
         ext_addr_q    <= PTR_RESET;
         ext_data_q    <= 8'h00;
         ext_wr_q      <= 1'b0;
         prog_commit_q <= 1'b0;
         prog_base_q   <= PTR_RESET;
      end else begin
         op_done_q     <= 1'b0;
         ext_wr_q      <= 1'b0;
         prog_commit_q <= 1'b0;
         case (st_q)
            ST_IDLE: begin
               op_ready_q <= ~op_valid;
               if (op_valid) begin
                  acc_q      <= acc_d;
                  fin_ptr_q  <= fin_d;
                  is_write_q <= op_write;
                  if (op_write) begin
                     st_q <= ST_WR_2;
                  end else begin
                     st_q         <= ST_RD_WAIT;
                     mem_addr_q   <= acc_d[PTR_W-1:1];
                     mem_rd_req_q <= 1'b1;
                  end
                  if (do_ext) begin
                     ext_addr_q <= acc_d;
                     ext_data_q <= latch_q;
                     ext_wr_q   <= 1'b1;
                  end
                  if (do_prog && blk_end) begin
                     prog_commit_q <= 1'b1;
                     prog_base_q   <= {acc_d[PTR_W-1:BLOCK_AW], 6'h00};
                  end
               end
            end
            ST_RD_WAIT: begin
               if (mem_rd_ack) begin
                  mem_rd_req_q <= 1'b0;
                  st_q         <= ST_FIN;
               end
            end
            ST_WR_2: begin
               st_q <= ST_FIN;
            end
            ST_FIN: begin
               op_done_q  <= 1'b1;
               op_ready_q <= 1'b1;
               st_q       <= ST_IDLE;
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Block staging buffer for programming mode.
   always_ff @(posedge aclk) begin
      if (do_prog) begin
         blk_buf[acc_d[BLOCK_AW-1:0]] <= latch_q;
      end
      prog_rd_byte_q <= blk_buf[prog_rd_idx];
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready  = wready_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;
   assign op_ready      = op_ready_q;
   assign op_done       = op_done_q;
   assign mem_word_addr = mem_addr_q;
   assign mem_rd_req    = mem_rd_req_q;
   assign ext_addr      = ext_addr_q;
   assign ext_data      = ext_data_q;
   assign ext_wr        = ext_wr_q;
   assign prog_commit   = prog_commit_q;
   assign prog_base     = prog_base_q;
   assign prog_rd_byte  = prog_rd_byte_q;

   // Checks on the pointer arithmetic and transfers.
   property p_cfg_bit_kept;
      @(posedge aclk) disable iff (!aresetn)
      (st_q == ST_FIN) |=> (ptr_q[CFG_BIT] == $past(acc_q[CFG_BIT]));
   endproperty
   a_cfg_bit_kept: assert property (p_cfg_bit_kept) else $error("select bit moved");

   property p_plain;
      @(posedge aclk) disable iff (!aresetn)
      (issue && op_mode == MODE_PLAIN) |=> (fin_ptr_q == $past(ptr_q)) && (acc_q == $past(ptr_q));
   endproperty
   a_plain: assert property (p_plain) else $error("plain form moved pointer");

   property p_post_inc;
      @(posedge aclk) disable iff (!aresetn)
      (issue && op_mode == MODE_POST_INC) |=>
         (acc_q == $past(ptr_q)) && (fin_ptr_q[20:0] == 21'($past(ptr_q[20:0]) + 21'h1));
   endproperty
   a_post_inc: assert property (p_post_inc) else $error("post increment wrong");

   property p_post_dec;
      @(posedge aclk) disable iff (!aresetn)
      (issue && op_mode == MODE_POST_DEC) |=>
         (acc_q == $past(ptr_q)) && (fin_ptr_q[20:0] == 21'($past(ptr_q[20:0]) - 21'h1));
   endproperty
   a_post_dec: assert property (p_post_dec) else $error("post decrement wrong");

   property p_pre_inc;
      @(posedge aclk) disable iff (!aresetn)
      (issue && op_mode == MODE_PRE_INC) |=>
         (acc_q[20:0] == 21'($past(ptr_q[20:0]) + 21'h1)) && (fin_ptr_q == acc_q);
   endproperty
   a_pre_inc: assert property (p_pre_inc) else $error("pre increment wrong");

   property p_rd_byte;
      @(posedge aclk) disable iff (!aresetn)
      (mem_rd_req_q && mem_rd_ack) |=>
         (latch_q == ($past(acc_q[0]) ? $past(mem_rd_word[15:8]) : $past(mem_rd_word[7:0])));
   endproperty
   a_rd_byte: assert property (p_rd_byte) else $error("latch byte wrong");

   property p_rd_addr;
      @(posedge aclk) disable iff (!aresetn)
      mem_rd_req_q |-> (mem_word_addr == acc_q[PTR_W-1:1]);
   endproperty
   a_rd_addr: assert property (p_rd_addr) else $error("read address wrong");

   property p_ext_wr;
      @(posedge aclk) disable iff (!aresetn)
      ext_wr_q |-> (ext_addr_q == acc_q) && (ext_data_q == latch_q) && (st_q == ST_WR_2);
   endproperty
   a_ext_wr: assert property (p_ext_wr) else $error("external write wrong");

   property p_wr_two;
      @(posedge aclk) disable iff (!aresetn)
      (issue && op_write) |=> (st_q == ST_WR_2) ##1 (st_q == ST_FIN) ##1 op_done_q;
   endproperty
   a_wr_two: assert property (p_wr_two) else $error("write not two cycles");

   property p_commit;
      @(posedge aclk) disable iff (!aresetn)
      prog_commit_q |-> (prog_base_q[BLOCK_AW-1:0] == 6'h00) && prog_mode_q && !ext_wr_q;
   endproperty
   a_commit: assert property (p_commit) else $error("block commit misaligned");

   property p_upper_zero;
      @(posedge aclk) disable iff (!aresetn)
      (ar_take && rd_addr == ADDR_PTR_UPPER) |=> (s_axi_rdata[7:6] == 2'h0);
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper top bits set");

   c_read_done: cover property (@(posedge aclk) disable iff (!aresetn)
      (st_q == ST_RD_WAIT) && mem_rd_ack ##2 op_done_q);
   c_post_dec_write: cover property (@(posedge aclk) disable iff (!aresetn)
      issue && op_write && op_mode == MODE_POST_DEC);
   c_block_commit: cover property (@(posedge aclk) disable iff (!aresetn) prog_commit_q);
   c_bus_write: cover property (@(posedge aclk) disable iff (!aresetn) wr_fire && hit_upper);
endmodule

// ### test/tpau_mem_model.sv
// Purpose: Program memory stand-in that answers word reads after a set lag.
// Assumes: Same clock as the block; one read request at a time.
// Notes:   Outside the answer cycle the data lines carry a changing pattern.
`timescale 1ns/100ps
module tpau_mem_model (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [3:0]  lag,
   input  wire logic        mem_rd_req,
   input  wire logic [20:0] mem_word_addr,
   output logic             mem_rd_ack,
   output logic [15:0]      mem_rd_word
);
   logic [3:0]  wait_q;
   logic [15:0] noise_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wait_q     <= 4'h0;
         mem_rd_ack <= 1'b0;
         noise_q    <= 16'h0000;
      end else begin
         noise_q    <= noise_q + 16'h9e37;
         mem_rd_ack <= 1'b0;
         if (mem_rd_req && !mem_rd_ack) begin
            if (wait_q >= lag) begin
               mem_rd_ack <= 1'b1;
               wait_q     <= 4'h0;
            end else begin
               wait_q <= wait_q + 4'h1;
            end
         end
      end
   end
   // High byte holds the odd address, low byte the even one.
   assign mem_rd_word = mem_rd_ack ? {mem_word_addr[7:0] ^ 8'h3c, mem_word_addr[7:0]} : noise_q;
endmodule

// ### test/tpau_table_access_tb_top.sv
// Purpose: Self-checking bench for the table pointer access unit.
// Assumes: AXI4-Lite master tasks and a core request task on aclk.
// Notes:   Memory data is a fixed function of the word address.
`timescale 1ns/100ps
module tpau_table_access_tb_top;
   import tpau_pkg::*;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, op_valid, op_write, op_ready, op_done, mem_rd_req, mem_rd_ack;
   logic        ext_wr, prog_commit;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, ext_data, prog_rd_byte, cap_d;
   logic [31:0] s_axi_wdata, s_axi_rdata, rv;
   logic [3:0]  s_axi_wstrb, lag;
   logic [1:0]  s_axi_bresp, s_axi_rresp, op_mode, resp;
   logic [20:0] mem_word_addr, cap_m;
   logic [15:0] mem_rd_word;
   logic [21:0] ext_addr, prog_base, cap_e, cap_b, ptr, p, acc, fin;
   logic [5:0]  prog_rd_idx;
   int          fails, samples_checked, n_ext, n_com, t_ext, t_com;

   tpau_table_access #(.EXT_MEM_PRESENT(1'b1)) uut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .op_valid(op_valid), .op_write(op_write), .op_mode(op_mode),
      .op_ready(op_ready), .op_done(op_done), .mem_word_addr(mem_word_addr),
      .mem_rd_req(mem_rd_req), .mem_rd_ack(mem_rd_ack), .mem_rd_word(mem_rd_word),
      .ext_addr(ext_addr), .ext_data(ext_data), .ext_wr(ext_wr), .prog_commit(prog_commit),
      .prog_base(prog_base), .prog_rd_idx(prog_rd_idx), .prog_rd_byte(prog_rd_byte));

   tpau_mem_model mem (.aclk(aclk), .aresetn(aresetn), .lag(lag), .mem_rd_req(mem_rd_req),
      .mem_word_addr(mem_word_addr), .mem_rd_ack(mem_rd_ack), .mem_rd_word(mem_rd_word));

   function automatic logic [7:0] mem_byte(input logic [21:0] a);
      return a[0] ? (a[8:1] ^ 8'h3c) : a[8:1];
   endfunction

   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task print_verdict;
      if (fails == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task give_up(input string nm);
      fails++;
      $display("[ERR] %s expected handshake seen none", nm);
      print_verdict();
   endtask

   task bus_wr(input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {24'h000000, d};
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 100);
      if (!s_axi_bvalid) give_up("write response");
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task bus_rd(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 100);
      if (!s_axi_rvalid) give_up("read data");
      rv = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task set_ptr(input logic [21:0] v);
      bus_wr(ADDR_PTR_LOW, v[7:0]);
      bus_wr(ADDR_PTR_HIGH, v[15:8]);
      bus_wr(ADDR_PTR_UPPER, {2'b00, v[21:16]});
   endtask

   task get_ptr;
      bus_rd(ADDR_PTR_LOW);
      ptr[7:0] = rv[7:0];
      bus_rd(ADDR_PTR_HIGH);
      ptr[15:8] = rv[7:0];
      bus_rd(ADDR_PTR_UPPER);
      ptr[21:16] = rv[5:0];
   endtask

   task core_op(input logic wr, input logic [1:0] md);
      int n;
      n = 0;
      n_ext = 0;
      n_com = 0;
      @(posedge aclk);
      op_valid <= 1'b1;
      op_write <= wr;
      op_mode <= md;
      do begin
         @(posedge aclk);
         n++;
      end while (!op_ready && n < 100);
      if (!op_ready) give_up("op_ready");
      op_valid <= 1'b0;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
         if (mem_rd_req) cap_m = mem_word_addr;
         if (ext_wr) begin
            n_ext++;
            cap_e = ext_addr;
            cap_d = ext_data;
         end
         if (prog_commit) begin
            n_com++;
            cap_b = prog_base;
         end
      end while (!op_done && n < 100);
      if (!op_done) give_up("op_done");
   endtask

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {op_valid, op_write, op_mode, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {prog_rd_idx, fails, samples_checked, t_ext, t_com} = '0;
      s_axi_wstrb = 4'h1;
      lag = 4'h2;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         bus_rd(8'(i * 4));
         check("reset value", rv, 32'h0);
      end
      bus_wr(ADDR_PTR_UPPER, 8'hff);
      bus_rd(ADDR_PTR_UPPER);
      check("upper byte", rv, 32'h3f);
      bus_wr(ADDR_LATCH, 8'ha5);
      bus_rd(ADDR_LATCH);
      check("latch", rv, 32'ha5);
      s_axi_wstrb <= 4'h0;
      bus_wr(ADDR_LATCH, 8'h5a);
      s_axi_wstrb <= 4'h1;
      check("masked write resp", 32'(resp), 32'(RESP_OKAY));
      bus_rd(ADDR_LATCH);
      check("masked write", rv, 32'ha5);
      bus_wr(8'h18, 8'h11);
      check("unmapped write", 32'(resp), 32'(RESP_SLVERR));
      bus_rd(8'h18);
      check("unmapped read", 32'(resp), 32'(RESP_SLVERR));
      // Reads at the top of the space; the increment must wrap inside 21 bits.
      set_ptr(22'h3fffff);
      core_op(1'b0, MODE_POST_INC);
      check("word addr", 32'(cap_m), 32'h1fffff);
      bus_rd(ADDR_LATCH);
      check("latch", rv, 32'(mem_byte(22'h3fffff)));
      get_ptr();
      check("pointer", 32'(ptr), 32'h200000);
      for (int m = 0; m < 4; m++) begin
         p = (m == 2) ? 22'h200000 : 22'h012344 + 22'(m);
         acc = (m == 3) ? {p[21], p[20:0] + 21'h1} : p;
         fin = (m == 0) ? p : (m == 2) ? {p[21], p[20:0] - 21'h1} : {p[21], p[20:0] + 21'h1};
         lag <= 4'(m * 3);
         set_ptr(p);
         core_op(1'b0, 2'(m));
         check("word addr", 32'(cap_m), 32'(acc[21:1]));
         bus_rd(ADDR_LATCH);
         check("latch", rv, 32'(mem_byte(acc)));
         get_ptr();
         check("pointer", 32'(ptr), 32'(fin));
      end
      bus_wr(ADDR_LATCH, 8'h96);
      set_ptr(22'h2abcde);
      core_op(1'b1, MODE_PRE_INC);
      check("ext writes", n_ext, 32'h1);
      check("ext addr", 32'(cap_e), 32'h2abcdf);
      check("ext data", 32'(cap_d), 32'h96);
      bus_wr(ADDR_CONTROL, 8'h01);
      bus_rd(ADDR_STATUS);
      check("status", rv, 32'h2);
      // One block from an even, block-aligned base.
      set_ptr(22'h000040);
      for (int i = 0; i < 64; i++) begin
         bus_wr(ADDR_LATCH, 8'(i + 128));
         core_op(1'b1, MODE_POST_INC);
         t_ext += n_ext;
         t_com += n_com;
      end
      check("commits", t_com, 32'h1);
      check("block base", 32'(cap_b), 32'h40);
      check("ext writes", t_ext, 32'h0);
      get_ptr();
      check("pointer", 32'(ptr), 32'h80);
      for (int k = 0; k < 64; k += 21) begin
         @(posedge aclk);
         prog_rd_idx <= 6'(k);
         repeat (2) @(posedge aclk);
         check("block byte", 32'(prog_rd_byte), 32'(k + 128));
      end
      print_verdict();
   end
endmodule
